// ---- rate_bitcount_map.svh ----
/*
 * Register offsets, field positions, reset values and divider figures for
 * the two-wire mode, rate and bit counter block.
 * Assumes it is included by bare name; it holds definitions only.
 */
//
// Contract
// - mode register reachable only while interface enabled
// - bit 7 picks MSB or LSB first
// - wait bit works only in master addressed
// - no wait: data and ack back to back
// - wait: flag set, clock held low
// - flag cleared to 0 ends the wait
// - divider select matters only as master
// - narrow range divides by 28 to 128
// - extended range divides by 56 to 256
// - addressed format: 000 is nine bits
// - synchronous format: 000 is eight bits
// - counter cleared at start and frame end
// - disabled interface stops and initialises everything; here the mode, status and mask registers keep their values
`ifndef RATE_BITCOUNT_MAP_SVH
`define RATE_BITCOUNT_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_MODE     8'h00
`define OFS_CTRL     8'h04
`define OFS_STATUS   8'h08
`define OFS_MASK     8'h0c
`define OFS_STATE    8'h10
`define OFS_DATA     8'h14

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define MODE_ORDER   7
`define MODE_WAIT    6
`define MODE_DIV_HI  5
`define MODE_DIV_LO  3
`define MODE_BC_HI   2
`define MODE_BC_LO   0
`define CTRL_IE      7
`define CTRL_MST     5
`define CTRL_SYNC    3
`define CTRL_EXT     2
`define CTRL_FLAG    0
`define ST_DONE      0
`define ST_WAITING   1
`define RST_REG8     8'h00
`define BC_ZERO      3'h0
`define LEN_ADDR_MAX 4'h9
`define LEN_SYNC_MAX 4'h8
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

// ****************************************************************
// serial clock divisors of the system clock
// ****************************************************************
`define DIV_N0 9'h01c
`define DIV_N1 9'h028
`define DIV_N2 9'h030
`define DIV_N3 9'h040
`define DIV_N4 9'h050
`define DIV_N5 9'h064
`define DIV_N6 9'h070
`define DIV_N7 9'h080
`define DIV_X0 9'h038
`define DIV_X1 9'h050
`define DIV_X2 9'h060
`define DIV_X3 9'h080
`define DIV_X4 9'h0a0
`define DIV_X5 9'h0c8
`define DIV_X6 9'h0e0
`define DIV_X7 9'h100

`endif

// ---- rate_bitcount_pkg.sv ----
/*
 * Types shared by the two-wire mode, rate and bit counter block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rate_bitcount_pkg;

	// serial engine phases
	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_LOW  = 2'b01,
		LINK_HIGH = 2'b10,
		LINK_WAIT = 2'b11
	} link_state_e;

	typedef logic [7:0] reg8_t;

endpackage

// ---- serial_rate_gen.sv ----
/*
 * Serial clock rate generator: one-cycle tick every half period of the
 * selected divisor of aclk.
 * Assumes run is low whenever the serial clock is not being generated.
 */
`timescale 1ns/1ns
`include "rate_bitcount_map.svh"

module serial_rate_gen (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       run,
	input  wire logic       ext,
	input  wire logic [2:0] sel,
	output logic            tick_q
);

	logic [8:0] cnt_q;
	logic [8:0] half;

	// ****************************************************************
	// divisor table
	// ****************************************************************
	function automatic logic [8:0] divisor(input logic e, input logic [2:0] s);
		logic [8:0] d;
		d = `DIV_N0;
		case ({e, s})
			4'h0: d = `DIV_N0;
			4'h1: d = `DIV_N1;
			4'h2: d = `DIV_N2;
			4'h3: d = `DIV_N3;
			4'h4: d = `DIV_N4;
			4'h5: d = `DIV_N5;
			4'h6: d = `DIV_N6;
			4'h7: d = `DIV_N7;
			4'h8: d = `DIV_X0;
			4'h9: d = `DIV_X1;
			4'ha: d = `DIV_X2;
			4'hb: d = `DIV_X3;
			4'hc: d = `DIV_X4;
			4'hd: d = `DIV_X5;
			4'he: d = `DIV_X6;
			default: d = `DIV_X7;
		endcase
		return d;
	endfunction

	assign half = (divisor(ext, sel) >> 1) - 9'h001;

	// half-period counter; all divisors are even so halves are exact
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt_q  <= 9'h000;
			tick_q <= 1'b0;
		end else if (cnt_q >= half) begin
			cnt_q  <= 9'h000;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 9'h001;
			tick_q <= 1'b0;
		end
	end

endmodule

// ---- i2c_mode_rate_bitcount.sv ----
/*
 * Mode, rate and bit counter control of a two-wire serial interface,
 * with an AXI4-Lite register slave, a small frame engine and interrupt.
 * Assumes open-drain pads outside; pin inputs are asynchronous.
 */
`timescale 1ns/1ns
`include "rate_bitcount_map.svh"

module i2c_mode_rate_bitcount (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [7:0] awaddr,
	input  wire logic       awvalid,
	output logic            awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0] wstrb,
	input  wire logic       wvalid,
	output logic            wready,
	output logic [1:0]      bresp,
	output logic            bvalid,
	input  wire logic       bready,
	input  wire logic [7:0] araddr,
	input  wire logic       arvalid,
	output logic            arready,
	output logic [31:0]     rdata,
	output logic [1:0]      rresp,
	output logic            rvalid,
	input  wire logic       rready,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe_n,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n,
	output logic            irq
);

	rate_bitcount_pkg::link_state_e state_q;
	rate_bitcount_pkg::reg8_t       mode_q;
	rate_bitcount_pkg::reg8_t       ctrl_q;
	rate_bitcount_pkg::reg8_t       wdat_q;
	rate_bitcount_pkg::reg8_t       tx_q;
	rate_bitcount_pkg::reg8_t       rx_q;
	logic [1:0]  status_q;
	logic [1:0]  mask_q;
	logic [3:0]  bits_q;
	logic        aw_have_q;
	logic        w_have_q;
	logic        wstrb0_q;
	logic [7:0]  wr_addr_q;
	logic        flag_q;
	logic        scl_s1_q, scl_s2_q, scl_s3_q;
	logic        sda_s1_q, sda_s2_q, sda_s3_q;
	logic        wr_go, wr_low;
	logic        ie, mst, sync_fmt, lsb_first, wait_active;
	logic [3:0]  len, last_data, bits_next;
	logic        tick, run, scl_rise, start_det;
	logic        frame_done, enter_wait, start_go;
	logic [7:0]  rd_data;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// frame lengths, synchronous and addressed
	function automatic logic [3:0] frame_len(input logic s, input logic [2:0] c);
		logic [3:0] n;
		n = {1'b0, c};
		if (s)
			n = (c == `BC_ZERO) ? `LEN_SYNC_MAX : {1'b0, c};
		else
			n = (c == `BC_ZERO) ? `LEN_ADDR_MAX : ({1'b0, c} + 4'h1);
		return n;
	endfunction

	function automatic logic out_bit(input logic [7:0] t, input logic lsb);
		return lsb ? t[0] : t[7];
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == `OFS_MODE || a == `OFS_CTRL || a == `OFS_STATUS ||
			a == `OFS_MASK || a == `OFS_STATE || a == `OFS_DATA;
	endfunction

	// ****************************************************************
	// decode of control fields
	// ****************************************************************
	assign ie        = ctrl_q[`CTRL_IE];
	assign mst       = ctrl_q[`CTRL_MST];
	assign sync_fmt  = ctrl_q[`CTRL_SYNC];
	assign lsb_first = mode_q[`MODE_ORDER];
	// wait only as master in addressed format
	assign wait_active = mode_q[`MODE_WAIT] && mst && !sync_fmt;
	assign len       = frame_len(sync_fmt, mode_q[`MODE_BC_HI:`MODE_BC_LO]);
	// the acknowledge is the last bit of an addressed frame
	assign last_data = sync_fmt ? len : len - 4'h1;
	assign bits_next = bits_q + 4'h1;
	assign wr_go     = aw_have_q && w_have_q && !bvalid;
	assign wr_low    = wr_go && wstrb0_q;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	// first stage is read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
			{sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
		end else begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_i, scl_s1_q, scl_s2_q};
			{sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_i, sda_s1_q, sda_s2_q};
		end
	end

	assign scl_rise  = scl_s2_q && !scl_s3_q;
	assign start_det = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;

	// ****************************************************************
	// rate generator
	// ****************************************************************
	// divider runs only as master
	assign run = ie && mst && (state_q == rate_bitcount_pkg::LINK_LOW ||
		state_q == rate_bitcount_pkg::LINK_HIGH);

	serial_rate_gen u_rate (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (run),
		.ext     (ctrl_q[`CTRL_EXT]),
		.sel     (mode_q[`MODE_DIV_HI:`MODE_DIV_LO]),
		.tick_q  (tick)
	);

	// ****************************************************************
	// frame engine
	// ****************************************************************
	// frame ends after programmed bit count
	assign frame_done = mst ? (state_q == rate_bitcount_pkg::LINK_HIGH && tick &&
		bits_next == len) : (ie && scl_rise && !start_det && bits_next == len);
	assign enter_wait = state_q == rate_bitcount_pkg::LINK_HIGH && tick &&
		wait_active && bits_next == last_data;
	assign start_go = wr_low && wr_addr_q == `OFS_DATA && ie && mst &&
		state_q == rate_bitcount_pkg::LINK_IDLE;

	// disabled interface forces idle and releases pins
	always_ff @(posedge aclk) begin
		if (!aresetn || !ie) begin
			state_q  <= rate_bitcount_pkg::LINK_IDLE;
			bits_q   <= 4'h0;
			tx_q     <= `RST_REG8;
			rx_q     <= `RST_REG8;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
		end else begin
			case (state_q)
				rate_bitcount_pkg::LINK_IDLE: begin
					if (start_go) begin
						state_q  <= rate_bitcount_pkg::LINK_LOW;
						bits_q   <= 4'h0;
						tx_q     <= wdat_q;
						scl_oe_n <= 1'b0;
						sda_oe_n <= out_bit(wdat_q, lsb_first);
					end else if (!mst) begin
						if (start_det) begin
							bits_q <= 4'h0;
						end else if (scl_rise) begin
							bits_q <= frame_done ? 4'h0 : bits_next;
							rx_q   <= lsb_first ? {sda_s2_q, rx_q[7:1]} :
								{rx_q[6:0], sda_s2_q};
						end
					end
				end
				rate_bitcount_pkg::LINK_LOW: begin
					if (tick) begin
						state_q  <= rate_bitcount_pkg::LINK_HIGH;
						scl_oe_n <= 1'b1;
					end
				end
				rate_bitcount_pkg::LINK_HIGH: begin
					if (tick) begin
						rx_q <= lsb_first ? {sda_s2_q, rx_q[7:1]} :
							{rx_q[6:0], sda_s2_q};
						tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
						if (frame_done) begin
							state_q  <= rate_bitcount_pkg::LINK_IDLE;
							bits_q   <= 4'h0;
							sda_oe_n <= 1'b1;
						end else begin
							bits_q   <= bits_next;
							scl_oe_n <= 1'b0;
							state_q  <= enter_wait ? rate_bitcount_pkg::LINK_WAIT :
								rate_bitcount_pkg::LINK_LOW;
							// release data for the far end's acknowledge
							if (!sync_fmt && bits_next == last_data)
								sda_oe_n <= 1'b1;
							else
								sda_oe_n <= out_bit(lsb_first ? {1'b0, tx_q[7:1]} :
									{tx_q[6:0], 1'b0}, lsb_first);
						end
					end
				end
				rate_bitcount_pkg::LINK_WAIT: begin
					// clock stays low until the flag is cleared
					if (!flag_q)
						state_q <= rate_bitcount_pkg::LINK_LOW;
				end
				default: state_q <= rate_bitcount_pkg::LINK_IDLE;
			endcase
		end
	end

	// pads only ever pull low
	always_ff @(posedge aclk) begin
		scl_o <= 1'b0;
		sda_o <= 1'b0;
	end

	// ****************************************************************
	// control register and transfer event flag
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `RST_REG8;
		end else if (wr_low && wr_addr_q == `OFS_CTRL) begin
			ctrl_q <= wdat_q;
		end
	end

	// software writes 0 to clear; a new event wins
	always_ff @(posedge aclk) begin
		if (!aresetn || !ie)
			flag_q <= 1'b0;
		else if (enter_wait || frame_done)
			flag_q <= 1'b1;
		else if (wr_low && wr_addr_q == `OFS_CTRL && !wdat_q[`CTRL_FLAG])
			flag_q <= 1'b0;
	end

	// ****************************************************************
	// mode register
	// ****************************************************************
	// all fields writable, reset to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= `RST_REG8;
		end else begin
			if (wr_low && wr_addr_q == `OFS_MODE && ie)
				mode_q <= wdat_q;
			// counter field back to zero; a disabled block leaves it alone
			if (ie && (start_det || frame_done))
				mode_q[`MODE_BC_HI:`MODE_BC_LO] <= `BC_ZERO;
		end
	end

	// ****************************************************************
	// interrupt status, mask and output
	// ****************************************************************
	// sticky bits, write one to clear; a new event wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_q <= 2'h0;
			mask_q   <= 2'h0;
		end else begin
			if (wr_low && wr_addr_q == `OFS_MASK)
				mask_q <= wdat_q[1:0];
			status_q <= (status_q & ~((wr_low && wr_addr_q == `OFS_STATUS) ?
				wdat_q[1:0] : 2'h0)) | {enter_wait, frame_done};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(status_q & mask_q);
	end

	// ****************************************************************
	// AXI4-Lite write channels
	// ****************************************************************
	// address and data are taken in either order, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			wr_addr_q <= 8'h00;
			wdat_q    <= `RST_REG8;
			wstrb0_q  <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_have_q <= 1'b1;
				awready   <= 1'b0;
				wr_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_q <= 1'b1;
				wready   <= 1'b0;
				wdat_q   <= wdata[7:0];
				wstrb0_q <= wstrb[0];
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= mapped(wr_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	always_comb begin
		case (araddr)
			`OFS_MODE:   rd_data = ie ? mode_q : `RST_REG8;
			`OFS_CTRL:   rd_data = {ctrl_q[7:1], flag_q};
			`OFS_STATUS: rd_data = {6'h00, status_q};
			`OFS_MASK:   rd_data = {6'h00, mask_q};
			`OFS_STATE:  rd_data = {state_q != rate_bitcount_pkg::LINK_IDLE,
				state_q == rate_bitcount_pkg::LINK_WAIT, 2'h0, bits_q};
			`OFS_DATA:   rd_data = rx_q;
			default:     rd_data = `RST_REG8;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= {24'h00_0000, rd_data};
			rresp   <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

endmodule

// ---- rate_bitcount_assertions.sv ----
/*
 * Checker for the two-wire mode, rate and bit counter block.
 * Assumes it is bound to the block's top module and sees only its ports.
 */
`timescale 1ns/1ns

module rate_bitcount_assertions (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [7:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [31:0] wdata,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [7:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        scl_oe_n,
	input wire logic        sda_oe_n,
	input wire logic        irq
);
	logic [7:0] a_q;
	logic [7:0] d_q;
	logic [7:0] ctrl_q;

	// ****************************************************************
	// control shadow
	// ****************************************************************
	// updated at the b handshake, a little late, so enable looks off longer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			a_q <= 8'h00;
			d_q <= 8'h00;
			ctrl_q <= 8'h00;
		end else begin
			if (awvalid && awready) a_q <= awaddr;
			if (wvalid && wready) d_q <= wdata[7:0];
			if (bvalid && bready && a_q == 8'h04 && bresp == 2'h0) ctrl_q <= d_q;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ****************************************************************
	// assertions
	// ****************************************************************
	rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	wr_answer_a: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write answer not closed");
	rd_miss_a: assert property (arvalid && arready && araddr > 8'h14 |=>
		rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read answered");
	rd_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	mode_hidden_a: assert property (arvalid && arready && araddr == 8'h00 && !ctrl_q[7]
		|=> rdata == 32'h0)
		else $error("mode visible while off");
	off_quiet_a: assert property ((!ctrl_q[7])[*3] |-> scl_oe_n && sda_oe_n)
		else $error("pins driven while off");
	slave_quiet_a: assert property ((ctrl_q[7] && !ctrl_q[5])[*3] |-> scl_oe_n && sda_oe_n)
		else $error("slave drives pins");
	scl_high_min_a: assert property ($rose(scl_oe_n) |-> scl_oe_n[*8])
		else $error("serial clock high too short");

	cover property ($fell(scl_oe_n));
	cover property (rvalid && rresp == 2'h2);
	cover property (irq);
endmodule

bind i2c_mode_rate_bitcount rate_bitcount_assertions chk (.aclk, .aresetn, .awaddr, .awvalid,
	.awready, .wdata, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
	.rdata, .rresp, .rvalid, .scl_oe_n, .sda_oe_n, .irq);

// ---- two_wire_remote.sv ----
/*
 * Remote two-wire device: pull-ups, bit counter, receive shifter, ack.
 * Assumes the block drives the serial clock, unless the bench plays master
 * by pulling the lines low itself.
 */
`timescale 1ns/1ns

module two_wire_remote (
	input wire logic  aclk,
	input wire logic  scl_oe_n,
	input wire logic  sda_oe_n,
	input wire logic  pull_scl,
	input wire logic  pull_sda,
	input wire logic  ack_en,
	input wire logic  clr,
	output logic      scl_i,
	output logic      sda_i,
	output logic [3:0] bits_q,
	output logic [7:0] rx_q
);
	logic scl_prev_q;

	// pull-ups: a released line reads high; the bench may pull either low
	assign scl_i = scl_oe_n & ~pull_scl;
	assign sda_i = sda_oe_n & ~pull_sda & ~(ack_en & (bits_q == 4'h8));

	// sample data on each serial clock rise
	always_ff @(posedge aclk) begin
		scl_prev_q <= scl_i;
		if (clr) begin
			bits_q <= 4'h0;
			rx_q <= 8'h00;
		end else if (scl_i && !scl_prev_q) begin
			bits_q <= bits_q + 4'h1;
			rx_q <= {rx_q[6:0], sda_i};
		end
	end
endmodule

// ---- tb_top.sv ----
/*
 * Self-checking bench for the two-wire mode, rate and bit counter block.
 * Assumes the checker is bound and the remote model sits on the pins.
 */
`timescale 1ns/1ns

module tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq, ack_en, clr;
	logic        scl_i, scl_o, scl_oe_n, sda_i, sda_o, sda_oe_n;
	logic        pull_scl, pull_sda;
	logic [7:0]  awaddr, araddr, rx;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, bits;
	logic [1:0]  bresp, rresp, wr_resp, rd_resp;
	int          fail_count, n_checks, n;

	i2c_mode_rate_bitcount DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .scl_i, .scl_o, .scl_oe_n, .sda_i, .sda_o, .sda_oe_n, .irq);
	two_wire_remote remote (.aclk, .scl_oe_n, .sda_oe_n, .pull_scl, .pull_sda, .ack_en, .clr,
		.scl_i, .sda_i,
		.bits_q(bits), .rx_q(rx));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// ****************************************************************
	// bus and compare tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// address and data offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				wr_resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				rd_resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask

	// poll status until the given bit shows
	task automatic poll(input int b);
		d = 32'h0;
		while (d[b] !== 1'b1) rd(8'h08);
	endtask

	task automatic start(input logic [7:0] v);
		@(posedge aclk) clr <= 1'b1;
		@(posedge aclk) clr <= 1'b0;
		wr(8'h14, v);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_regs;
		for (int a = 0; a < 16; a += 4) begin
			rd(a[7:0]);
			chk(d, 32'h0);
		end
		rd(8'h18);
		chk(rd_resp, 2'h2);
		chk(d, 32'h0);
		wr(8'h20, 8'hff);
		chk(wr_resp, 2'h2);
		wr(8'h00, 8'h5a);
		wr(8'h04, 8'h80);
		rd(8'h00);
		chk(d, 32'h0);
		wr(8'h00, 8'h5a);
		rd(8'h00);
		chk(d, 32'h5a);
		// a write without its low byte lane leaves the register alone
		wstrb <= 4'he;
		wr(8'h0c, 8'h03);
		wstrb <= 4'hf;
		rd(8'h0c);
		chk(d, 32'h0);
		wr(8'h04, 8'h00);
		rd(8'h00);
		chk(d, 32'h0);
		wr(8'h04, 8'h80);
		wr(8'h00, 8'h00);
		wr(8'h04, 8'h00);
		$display("test regs done");
	endtask

	// every divider code in both ranges, aborted after the first high phase
	task automatic t_rates;
		int dv[16] = '{28, 40, 48, 64, 80, 100, 112, 128, 56, 80, 96, 128, 160, 200, 224, 256};
		for (int i = 0; i < 16; i++) begin
			wr(8'h04, (i > 7) ? 8'ha4 : 8'ha0);
			wr(8'h00, {2'b00, i[2:0], 3'b000});
			start(8'hff);
			while (scl_oe_n !== 1'b0) @(posedge aclk);
			while (scl_oe_n !== 1'b1) @(posedge aclk);
			n = 0;
			while (scl_oe_n === 1'b1) begin
				@(posedge aclk);
				n++;
			end
			chk(n, dv[i] / 2);
			wr(8'h04, 8'h00);
			repeat (3) @(posedge aclk);
			chk({scl_oe_n, sda_oe_n}, 2'b11);
		end
		$display("test rates done");
	endtask

	// synchronous and addressed frames, both orders, short counts
	task automatic t_frames;
		logic [7:0] cv[4] = '{8'ha8, 8'ha8, 8'ha8, 8'ha0};
		logic [7:0] mv[4] = '{8'h40, 8'hc0, 8'h03, 8'h03};
		logic [7:0] tx[4] = '{8'hc5, 8'hc5, 8'he0, 8'ha0};
		logic [7:0] rm[4] = '{8'hff, 8'hff, 8'h07, 8'h0f};
		logic [7:0] re[4] = '{8'hc5, 8'ha3, 8'h07, 8'h0b};
		logic [3:0] nb[4] = '{4'h8, 4'h8, 4'h3, 4'h4};
		for (int i = 0; i < 4; i++) begin
			wr(8'h04, cv[i]);
			wr(8'h00, mv[i]);
			start(tx[i]);
			poll(0);
			chk(d[1:0], 2'b01);
			chk(bits, nb[i]);
			chk(rx & rm[i], re[i]);
			rd(8'h00);
			chk(d, {24'h0, mv[i] & 8'hf8});
			wr(8'h08, 8'h03);
			wr(8'h04, 8'h00);
		end
		$display("test frames done");
	endtask

	task automatic t_wait;
		ack_en <= 1'b1;
		wr(8'h04, 8'ha0);
		wr(8'h00, 8'h40);
		wr(8'h0c, 8'h02);
		start(8'h96);
		poll(1);
		chk(bits, 4'h8);
		chk(scl_oe_n, 1'b0);
		chk(irq, 1'b1);
		repeat (200) @(posedge aclk);
		chk(bits, 4'h8);
		rd(8'h04);
		chk(d[0], 1'b1);
		wr(8'h04, 8'ha0);
		poll(0);
		chk(bits, 4'h9);
		chk(rx, 8'h2c);
		wr(8'h08, 8'h02);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		rd(8'h08);
		chk(d, 32'h1);
		wr(8'h08, 8'h01);
		wr(8'h04, 8'h00);
		$display("test wait done");
	endtask

	// bench pulls the clock line low and lets it go, k times
	task automatic scl_pulses(input int k);
		repeat (k) begin
			@(posedge aclk);
			pull_scl <= 1'b1;
			repeat (4) @(posedge aclk);
			pull_scl <= 1'b0;
			repeat (4) @(posedge aclk);
		end
	endtask

	// bench as remote master: the block as slave counts clocks, never drives
	task automatic t_slave;
		ack_en <= 1'b0;
		wr(8'h04, 8'h80);
		wr(8'h00, 8'h03);
		scl_pulses(2);
		rd(8'h10);
		chk(d, 32'h2);
		// start: data falls while the clock is high
		pull_sda <= 1'b1;
		repeat (4) @(posedge aclk);
		pull_scl <= 1'b1;
		repeat (4) @(posedge aclk);
		rd(8'h10);
		chk(d, 32'h0);
		rd(8'h00);
		chk(d, 32'h0);
		wr(8'h00, 8'h03);
		pull_sda <= 1'b0;
		scl_pulses(4);
		rd(8'h08);
		chk(d, 32'h1);
		rd(8'h00);
		chk(d, 32'h0);
		rd(8'h14);
		chk(d, 32'h3f);
		chk({scl_oe_n, sda_oe_n}, 2'b11);
		chk({scl_o, sda_o}, 2'b00);
		wr(8'h08, 8'h01);
		wr(8'h04, 8'h00);
		$display("test slave done");
	endtask

	// ****************************************************************
	// run control
	// ****************************************************************
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// a hung handshake or frame ends here
	initial begin
		#800000;
		fail_count++;
		wrap_up;
	end

	initial begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		ack_en = 1'b0;
		pull_scl = 1'b0;
		pull_sda = 1'b0;
		clr = 1'b1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		clr <= 1'b0;
		t_regs;
		t_rates;
		t_frames;
		t_wait;
		t_slave;
		wrap_up;
	end
endmodule
